// File: common/pmc_pkg.sv
/*
  Shared constants of the power-management configuration bank: register
  offsets, field positions, reset values and the delay timebase.
  Assumes a single 10 MHz system clock, whichever oscillator feeds it.
*/
`default_nettype none
package pmc_pkg;
  localparam int REG_ADDR_W = 8;
  localparam int REG_DATA_W = 8;
  localparam int RAIL_N = 4;
  // register offsets
  localparam logic [7:0] OFS_RAIL_DELAY_BASE = 8'h0C;
  localparam logic [7:0] OFS_DEVICE_CONFIGURATION = 8'h13;
  localparam logic [7:0] OFS_PLL_CLOCK_CONTROL = 8'h14;
  localparam logic [7:0] OFS_POWER_OK_CONTROL_ONE = 8'h15;
  localparam logic [7:0] OFS_POWER_OK_CONTROL_TWO = 8'h16;
  localparam logic [7:0] OFS_BLOCK_STATUS = 8'h1F;
  // reset values
  localparam logic [7:0] RST_RAIL_DELAY = 8'h00;
  localparam logic [7:0] RST_DEVICE_CONFIGURATION = 8'h00;
  localparam logic [7:0] RST_PLL_CLOCK_CONTROL = 8'h00;
  localparam logic [7:0] RST_POWER_OK_CONTROL_ONE = 8'h00;
  localparam logic [7:0] RST_POWER_OK_CONTROL_TWO = 8'h00;
  // device_configuration fields
  localparam int CFG_STARTUP_WIDE = 6;
  localparam int CFG_SHUTDOWN_WIDE = 5;
  localparam int CFG_CLOCK_PIN_ROLE = 4;
  localparam int CFG_CLOCK_PIN_PD = 3;
  localparam int CFG_ENABLE_PIN_PD = 2;
  localparam int CFG_THERMAL_THRESH = 1;
  localparam int CFG_SPREAD = 0;
  // pll_clock_control fields
  localparam int PLL_ENABLE = 6;
  localparam int PLL_FREQ_LSB = 0;
  localparam int PLL_FREQ_W = 5;
  localparam logic [4:0] PLL_FREQ_MAX = 5'h17;
  // power_ok_control_one fields
  localparam int POK_POLARITY = 7;
  localparam int POK_OPEN_DRAIN = 6;
  localparam int POK_LINEAR_WINDOW = 5;
  localparam int POK_SWITCHER_WINDOW = 4;
  localparam int POK_MONITOR_LSB = 0;
  // rail delay register fields
  localparam int DLY_STARTUP_LSB = 0;
  localparam int DLY_SHUTDOWN_LSB = 4;
  localparam int DLY_CODE_W = 4;
  // timebase
  localparam int CLK_PERIOD_NS = 100;
  localparam int HALF_MS_NS = 500000;
  localparam int HALF_MS_CYCLES = HALF_MS_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// File: logic/pmc_sync.sv
/*
  Two-flop synchroniser for a group of asynchronous levels.
  Assumes inputs are quasi-static levels; multi-bit groups may skew by a cycle.
*/
`default_nettype none
module pmc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule
`default_nettype wire

// File: logic/pmc_delay_cnt.sv
/*
  Start-up and shutdown delay of one output after the enable level's edges.
  Assumes a one-cycle half-millisecond tick from a free-running divider.
*/
`default_nettype none
module pmc_delay_cnt (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // timing
  input wire logic half_ms_tick,
  input wire logic enable_level,
  input wire logic [3:0] startup_code,
  input wire logic [3:0] shutdown_code,
  input wire logic startup_wide,
  input wire logic shutdown_wide,
  // result
  output logic rail_on
);
  typedef enum logic [1:0] {ST_OFF, ST_WAIT_ON, ST_ON, ST_WAIT_OFF} pmc_dly_state_t;
  pmc_dly_state_t state_ff;
  pmc_dly_state_t nxt_state;
  logic en_q_ff;
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic [4:0] target_ff;
  logic [4:0] nxt_target;
  logic rail_on_ff;
  wire rise = enable_level & ~en_q_ff;
  wire fall = ~enable_level & en_q_ff;
  // wide range counts two half-ms ticks per step
  wire [4:0] up_target = startup_wide ? {startup_code, 1'b0} : {1'b0, startup_code}; // RL1 RL18
  wire [4:0] down_target = shutdown_wide ? {shutdown_code, 1'b0} : {1'b0, shutdown_code}; // RL2
  wire done = cnt_ff == target_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_target = target_ff;
    nxt_cnt = cnt_ff;
    unique case (state_ff)
      ST_OFF: begin
        if (rise) begin
          nxt_state = ST_WAIT_ON;
          nxt_target = up_target;
          nxt_cnt = 5'h00;
        end
      end
      ST_WAIT_ON: begin
        if (fall) begin
          nxt_state = ST_OFF;
        end else if (done) begin
          nxt_state = ST_ON;
        end else if (half_ms_tick) begin
          nxt_cnt = cnt_ff + 5'h01;
        end
      end
      ST_ON: begin
        if (fall) begin
          nxt_state = ST_WAIT_OFF;
          nxt_target = down_target;
          nxt_cnt = 5'h00;
        end
      end
      ST_WAIT_OFF: begin
        if (rise) begin
          nxt_state = ST_ON;
        end else if (done) begin
          nxt_state = ST_OFF;
        end else if (half_ms_tick) begin
          nxt_cnt = cnt_ff + 5'h01;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_OFF;
      en_q_ff <= 1'b0;
      cnt_ff <= 5'h00;
      target_ff <= 5'h00;
      rail_on_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      en_q_ff <= enable_level;
      cnt_ff <= nxt_cnt;
      target_ff <= nxt_target;
      rail_on_ff <= (nxt_state == ST_ON) || (nxt_state == ST_WAIT_OFF);
    end
  end

  assign rail_on = rail_on_ff;
endmodule
`default_nettype wire

// File: logic/pmc_config_top.sv
/*
  Configuration bank of the power-management control: device configuration,
  clock source selection, power-ok aggregation and output delay sequencing.
  Assumes an internal register port driven by the serial interface engine,
  and analog comparator and clock-detect levels arriving asynchronously.
*/
`default_nettype none
// What this block does
// RL1 - start-up range: 0.5 ms or 1 ms steps
// RL2 - shutdown range: 0.5 ms or 1 ms steps
// RL3 - bit 4 picks clock pin role
// RL4 - bit 3 drives clock pin pull-down
// RL5 - bit 2 drives enable pin pull-down
// RL6 - bit 1 picks thermal warning threshold
// RL7 - bit 0 turns spread spectrum on
// RL8 - PLL off forces internal oscillator
// RL9 - PLL on uses external clock automatically
// RL10 - clock appear/disappear raises event
// RL11 - software writes zero to bit 5
// RL12 - frequency code plus one MHz, max 0x17
// RL13 - bit 7 sets power-ok polarity
// RL14 - bit 6 selects open-drain power-ok drive
// RL15 - linear regulators: window or undervoltage only
// RL16 - switchers: window or undervoltage only
// RL17 - per-rail power-ok monitoring enables
// RL18 - start-up code delays output rise
// RL19 - power-ok valid only if enabled rails pass
// RL20 - delay timebase from active system clock
module pmc_config_top
  import pmc_pkg::*;
#(
  parameter int HALF_MS_CYCLES_P = pmc_pkg::HALF_MS_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [pmc_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic [pmc_pkg::REG_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pmc_pkg::REG_DATA_W-1:0] reg_rdata,
  // pins and analog levels (asynchronous)
  input wire logic enable_pin,
  input wire logic external_clock_present,
  input wire logic [pmc_pkg::RAIL_N-1:0] rail_under_ok,
  input wire logic [pmc_pkg::RAIL_N-1:0] rail_over_ok,
  input wire logic die_above_low_threshold,
  input wire logic die_above_high_threshold,
  // operating mode from the device state machine
  input wire logic mode_standby_or_active,
  // device configuration outputs
  output logic clock_pin_is_clock_input,
  output logic clock_pin_is_second_general_output,
  output logic clock_pin_pulldown,
  output logic enable_pin_pulldown,
  output logic thermal_warning,
  output logic spread_spectrum_on,
  // clock source
  output logic pll_enable,
  output logic use_external_clock,
  output logic [4:0] external_clock_freq_code,
  output logic external_clock_event,
  // power-ok pin
  output logic power_ok_output_out,
  output logic power_ok_output_oe,
  // sequenced rail enables
  output logic [pmc_pkg::RAIL_N-1:0] rail_enable
);
  import pmc_pkg::*;

  logic [7:0] cfg_ff;
  logic [7:0] pll_ff;
  logic [7:0] pok1_ff;
  logic [7:0] pok2_ff;
  logic [7:0] rail_delay_ff [RAIL_N];
  logic [7:0] rdata_ff;
  logic [15:0] tb_cnt_ff;
  logic half_ms_tick_ff;
  logic ext_present_q_ff;
  logic event_ff;
  logic pok_out_ff;
  logic pok_oe_ff;
  logic warn_ff;
  logic use_ext_ff;

  // synchronised pin and analog levels
  logic enable_s;
  logic ext_present_s;
  logic [RAIL_N-1:0] under_ok_s;
  logic [RAIL_N-1:0] over_ok_s;
  logic die_low_s;
  logic die_high_s;

  pmc_sync #(.W(1)) u_sync_en (
    .clk(clk),
    .rst(rst),
    .async_in(enable_pin),
    .sync_out(enable_s)
  );

  pmc_sync #(.W(1)) u_sync_clk (
    .clk(clk),
    .rst(rst),
    .async_in(external_clock_present),
    .sync_out(ext_present_s)
  );

  pmc_sync #(.W(RAIL_N)) u_sync_uv (
    .clk(clk),
    .rst(rst),
    .async_in(rail_under_ok),
    .sync_out(under_ok_s)
  );

  pmc_sync #(.W(RAIL_N)) u_sync_ov (
    .clk(clk),
    .rst(rst),
    .async_in(rail_over_ok),
    .sync_out(over_ok_s)
  );

  pmc_sync #(.W(2)) u_sync_temp (
    .clk(clk),
    .rst(rst),
    .async_in({die_above_high_threshold, die_above_low_threshold}),
    .sync_out({die_high_s, die_low_s})
  );

  // register decode
  // an unmapped offset matches no decode, so such a write is simply dropped
  wire wr_cfg = reg_wr && (reg_addr == OFS_DEVICE_CONFIGURATION);
  wire wr_pll = reg_wr && (reg_addr == OFS_PLL_CLOCK_CONTROL);
  wire wr_pok1 = reg_wr && (reg_addr == OFS_POWER_OK_CONTROL_ONE);
  wire wr_pok2 = reg_wr && (reg_addr == OFS_POWER_OK_CONTROL_TWO);
  // a reserved frequency code is refused and the previous code kept
  wire [4:0] wr_freq = reg_wdata[PLL_FREQ_LSB +: PLL_FREQ_W];
  wire freq_legal = wr_freq <= PLL_FREQ_MAX; // RL12
  wire [4:0] nxt_freq = freq_legal ? wr_freq : pll_ff[PLL_FREQ_LSB +: PLL_FREQ_W]; // RL12
  wire [7:0] nxt_pll = {reg_wdata[7:PLL_FREQ_W], nxt_freq};

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_ff <= RST_DEVICE_CONFIGURATION;
    end else if (wr_cfg) begin
      cfg_ff <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pll_ff <= RST_PLL_CLOCK_CONTROL;
    end else if (wr_pll) begin
      pll_ff <= nxt_pll; // RL12
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pok1_ff <= RST_POWER_OK_CONTROL_ONE;
    end else if (wr_pok1) begin
      pok1_ff <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pok2_ff <= RST_POWER_OK_CONTROL_TWO;
    end else if (wr_pok2) begin
      pok2_ff <= reg_wdata;
    end
  end

  // per-rail delay registers and sequencers; delays count from the enable pin edges
  logic [RAIL_N-1:0] rail_on;

  genvar gi;
  generate
    for (gi = 0; gi < RAIL_N; gi++) begin : g_rail
      wire wr_dly = reg_wr && (reg_addr == OFS_RAIL_DELAY_BASE + 8'(gi));

      always_ff @(posedge clk) begin
        if (rst) begin
          rail_delay_ff[gi] <= RST_RAIL_DELAY;
        end else if (wr_dly) begin
          rail_delay_ff[gi] <= reg_wdata;
        end
      end

      pmc_delay_cnt u_delay (
        .clk(clk),
        .rst(rst),
        .half_ms_tick(half_ms_tick_ff),
        .enable_level(enable_s),
        .startup_code(rail_delay_ff[gi][DLY_STARTUP_LSB +: DLY_CODE_W]),
        .shutdown_code(rail_delay_ff[gi][DLY_SHUTDOWN_LSB +: DLY_CODE_W]),
        .startup_wide(cfg_ff[CFG_STARTUP_WIDE]), // RL1
        .shutdown_wide(cfg_ff[CFG_SHUTDOWN_WIDE]), // RL2
        .rail_on(rail_on[gi]) // RL18
      );
    end
  endgenerate

  assign rail_enable = rail_on;

  // half-millisecond timebase; clk is whatever oscillator is currently selected,
  // so both delay ranges follow the active source without extra logic
  wire tb_wrap = tb_cnt_ff == 16'(HALF_MS_CYCLES_P - 1);

  always_ff @(posedge clk) begin
    if (rst) begin
      tb_cnt_ff <= 16'h0000;
    end else begin
      tb_cnt_ff <= tb_wrap ? 16'h0000 : tb_cnt_ff + 16'h0001; // RL20
    end
  end

  // the tick is free-running, so a delay may end up to one tick early
  always_ff @(posedge clk) begin
    if (rst) begin
      half_ms_tick_ff <= 1'b0;
    end else begin
      half_ms_tick_ff <= tb_wrap; // RL20
    end
  end

  // clock source selection
  wire pll_on = pll_ff[PLL_ENABLE] & mode_standby_or_active; // RL8 RL9
  wire pin_is_clock = cfg_ff[CFG_CLOCK_PIN_ROLE]; // RL3
  wire clock_seen = pin_is_clock & ext_present_s;
  wire nxt_use_ext = pll_on & clock_seen; // RL9
  // appear and disappear both count; detection only while the PLL runs
  wire clock_changed = clock_seen ^ ext_present_q_ff;
  wire nxt_event = pll_on & clock_changed; // RL10

  // the history runs with the PLL off too, so turning it on raises no stale event
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_present_q_ff <= 1'b0;
      event_ff <= 1'b0;
    end else begin
      ext_present_q_ff <= clock_seen;
      event_ff <= nxt_event; // RL10
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      use_ext_ff <= 1'b0;
    end else begin
      use_ext_ff <= nxt_use_ext; // RL8
    end
  end

  // thermal warning compare; both comparators are synchronised, and the registered warning follows a new threshold a cycle later
  wire nxt_warn = cfg_ff[CFG_THERMAL_THRESH] ? die_high_s : die_low_s; // RL6

  always_ff @(posedge clk) begin
    if (rst) begin
      warn_ff <= 1'b0;
    end else begin
      warn_ff <= nxt_warn; // RL6
    end
  end

  // power-ok aggregation; rails 0,1 are switchers, rails 2,3 are linear regulators
  wire [RAIL_N-1:0] rail_pass;

  generate
    for (gi = 0; gi < RAIL_N; gi++) begin : g_pass
      // overvoltage is ignored unless the window check of the rail's kind is on
      wire window_on = (gi < RAIL_N / 2) ? pok1_ff[POK_SWITCHER_WINDOW] : pok1_ff[POK_LINEAR_WINDOW]; // RL15 RL16
      assign rail_pass[gi] = under_ok_s[gi] & (over_ok_s[gi] | ~window_on); // RL15 RL16
    end
  endgenerate

  wire [RAIL_N-1:0] monitor = pok1_ff[POK_MONITOR_LSB +: RAIL_N]; // RL17
  wire outputs_valid = &(rail_pass | ~monitor); // RL17 RL19
  wire pok_level = outputs_valid ^ pok1_ff[POK_POLARITY]; // RL13
  // open drain only ever pulls low; a high level releases the pin
  wire nxt_pok_oe = pok1_ff[POK_OPEN_DRAIN] ? ~pok_level : 1'b1; // RL14
  wire nxt_pok_out = pok1_ff[POK_OPEN_DRAIN] ? 1'b0 : pok_level; // RL14

  // registered so the pin cannot glitch while rail inputs and settings change
  always_ff @(posedge clk) begin
    if (rst) begin
      pok_out_ff <= 1'b0;
      pok_oe_ff <= 1'b0;
    end else begin
      pok_out_ff <= nxt_pok_out; // RL13
      pok_oe_ff <= nxt_pok_oe; // RL14
    end
  end

  // read-back; status register shows live block state
  wire [7:0] status_word = {rail_on, outputs_valid, warn_ff, use_ext_ff, ext_present_s};
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < RAIL_N; i++) begin
      if (reg_addr == OFS_RAIL_DELAY_BASE + 8'(i)) begin
        rd_mux = rail_delay_ff[i];
      end
    end
    unique case (reg_addr)
      OFS_DEVICE_CONFIGURATION: rd_mux = cfg_ff;
      OFS_PLL_CLOCK_CONTROL: rd_mux = pll_ff;
      OFS_POWER_OK_CONTROL_ONE: rd_mux = pok1_ff;
      OFS_POWER_OK_CONTROL_TWO: rd_mux = pok2_ff;
      OFS_BLOCK_STATUS: rd_mux = status_word;
      default: rd_mux = rd_mux;
    endcase
  end

  // read data holds until the next read strobe, so a slow serial engine may shift it out
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      rdata_ff <= rd_mux;
    end
  end

  assign reg_rdata = rdata_ff;

  // configuration outputs; all but pll_enable and the registered warning and clock-source flags come straight from register bits
  assign clock_pin_is_clock_input = pin_is_clock; // RL3
  assign clock_pin_is_second_general_output = ~pin_is_clock; // RL3
  assign clock_pin_pulldown = cfg_ff[CFG_CLOCK_PIN_PD]; // RL4
  assign enable_pin_pulldown = cfg_ff[CFG_ENABLE_PIN_PD]; // RL5
  assign spread_spectrum_on = cfg_ff[CFG_SPREAD]; // RL7
  assign thermal_warning = warn_ff;
  assign pll_enable = pll_on; // RL8
  assign use_external_clock = use_ext_ff;
  assign external_clock_freq_code = pll_ff[PLL_FREQ_LSB +: PLL_FREQ_W]; // RL12
  assign external_clock_event = event_ff;

  // power-ok pin drive
  assign power_ok_output_out = pok_out_ff;
  assign power_ok_output_oe = pok_oe_ff;
endmodule
`default_nettype wire

// File: sim/pmc_config_chk.sv
/*
  Port checker of the configuration bank.
  Assumes one-cycle register strobes and registered read data.
*/
`default_nettype none
module pmc_config_chk
  import pmc_pkg::*;
#(
  parameter int HALF_MS_CYCLES_P = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [pmc_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic [pmc_pkg::REG_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [pmc_pkg::REG_DATA_W-1:0] reg_rdata,
  // mode and outputs
  input wire logic mode_standby_or_active,
  input wire logic clock_pin_is_clock_input,
  input wire logic clock_pin_is_second_general_output,
  input wire logic clock_pin_pulldown,
  input wire logic enable_pin_pulldown,
  input wire logic spread_spectrum_on,
  input wire logic pll_enable,
  input wire logic use_external_clock,
  input wire logic [4:0] external_clock_freq_code,
  input wire logic external_clock_event,
  input wire logic power_ok_output_out,
  input wire logic power_ok_output_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic cfg_wr = reg_wr && reg_addr == OFS_DEVICE_CONFIGURATION;
  wire logic pll_wr = reg_wr && reg_addr == OFS_PLL_CLOCK_CONTROL;
  wire logic pok_wr = reg_wr && reg_addr == OFS_POWER_OK_CONTROL_ONE;
  wire logic pok_rd = reg_rd && reg_addr == OFS_POWER_OK_CONTROL_ONE;
  role_excl_a: assert property (clock_pin_is_clock_input != clock_pin_is_second_general_output)
    else $error("clock pin roles clash");
  role_wr_a: assert property (cfg_wr |=> clock_pin_is_clock_input == $past(reg_wdata[4]))
    else $error("clock pin role not written");
  pd_wr_a: assert property (cfg_wr |=> {clock_pin_pulldown, enable_pin_pulldown} == $past(reg_wdata[3:2]))
    else $error("pull-down bits not written");
  spread_wr_a: assert property (cfg_wr |=> spread_spectrum_on == $past(reg_wdata[0]))
    else $error("spread bit not written");
  pll_off_a: assert property (!pll_enable |=> !use_external_clock)
    else $error("external clock used with pll off");
  pll_mode_a: assert property (!mode_standby_or_active |-> !pll_enable)
    else $error("pll on outside standby and active");
  // two stable cycles of pll enable rule out a rise caused by the enable itself
  clk_event_a: assert property (pll_enable && $past(pll_enable) && $past(pll_enable, 2)
    && $changed(use_external_clock) |-> ##[0:1] external_clock_event) else $error("clock event missing");
  freq_wr_a: assert property (pll_wr && reg_wdata[4:0] <= PLL_FREQ_MAX
    |=> external_clock_freq_code == $past(reg_wdata[4:0])) else $error("frequency code not written");
  freq_keep_a: assert property (pll_wr && reg_wdata[4:0] > PLL_FREQ_MAX |=> $stable(external_clock_freq_code))
    else $error("reserved frequency code taken");
  pok_drive_a: assert property (power_ok_output_out |-> power_ok_output_oe)
    else $error("power-ok high while released");
  pok_rw_a: assert property (pok_wr ##2 pok_rd |=> reg_rdata == $past(reg_wdata, 3))
    else $error("power-ok control readback differs");
endmodule
bind pmc_config_top pmc_config_chk #(.HALF_MS_CYCLES_P(HALF_MS_CYCLES_P)) chk_u (
  .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mode_standby_or_active,
  .clock_pin_is_clock_input, .clock_pin_is_second_general_output, .clock_pin_pulldown, .enable_pin_pulldown,
  .spread_spectrum_on, .pll_enable, .use_external_clock, .external_clock_freq_code, .external_clock_event,
  .power_ok_output_out, .power_ok_output_oe
);
`default_nettype wire

// File: sim/pmc_host_model.sv
/*
  Host side of the register port: write and read tasks with one-cycle strobes.
  Assumes its caller runs one task at a time.
*/
`default_nettype none
module pmc_host_model
  import pmc_pkg::*;
(
  // clock
  input wire logic clk,
  // register port
  output logic [pmc_pkg::REG_ADDR_W-1:0] reg_addr,
  output logic [pmc_pkg::REG_DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [pmc_pkg::REG_DATA_W-1:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // raw lets a refusal scenario send the reserved bit 5 as given; frequency codes are never masked
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic raw);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = (raw || a != OFS_PLL_CLOCK_CONTROL) ? d : (d & 8'hDF);
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// File: sim/pmc_config_top_tb.sv
/*
  Self-checking bench of the configuration bank against a reference model.
  Assumes the host model owns the register port; pins are driven here.
*/
`default_nettype none
module pmc_config_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pmc_pkg::*;
  localparam int HM = 4;
  logic clk, rst, reg_wr, reg_rd, enable_pin, external_clock_present, die_above_low_threshold;
  logic die_above_high_threshold, mode_standby_or_active, clock_pin_is_clock_input, ok;
  logic clock_pin_is_second_general_output, clock_pin_pulldown, enable_pin_pulldown, thermal_warning;
  logic spread_spectrum_on, pll_enable, use_external_clock, external_clock_event;
  logic power_ok_output_out, power_ok_output_oe;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v, c;
  logic [3:0] rail_under_ok, rail_over_ok, rail_enable;
  logic [4:0] external_clock_freq_code;
  logic [7:0] regs [0:63];
  logic [7:0] ra [5] = '{8'h0C, 8'h13, 8'h15, 8'h16, 8'h20};
  int fails = 0;
  int n_checks = 0;
  int n, t;
  pmc_config_top #(.HALF_MS_CYCLES_P(HM)) dut_u (
    .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .enable_pin, .external_clock_present,
    .rail_under_ok, .rail_over_ok, .die_above_low_threshold, .die_above_high_threshold, .mode_standby_or_active,
    .clock_pin_is_clock_input, .clock_pin_is_second_general_output, .clock_pin_pulldown, .enable_pin_pulldown,
    .thermal_warning, .spread_spectrum_on, .pll_enable, .use_external_clock, .external_clock_freq_code,
    .external_clock_event, .power_ok_output_out, .power_ok_output_oe, .rail_enable
  );
  pmc_host_model host_u (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic hold(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // sel picks the clock event, else the first rail enable; a used-up bound ends the run
  task automatic wait_on(input logic sel, input logic lvl, input int lim);
    n = 0;
    while ((sel ? external_clock_event : rail_enable[0]) !== lvl && n < lim) begin
      hold(1);
      n++;
    end
    if (n == lim) begin
      fails++;
      end_of_test();
    end
  endtask
  initial begin
    {rst, enable_pin, external_clock_present, die_above_low_threshold, die_above_high_threshold} = 5'h10;
    mode_standby_or_active = 1'b0;
    rail_under_ok = 4'h0;
    rail_over_ok = 4'h0;
    void'($urandom(32'h6E03));
    foreach (regs[i]) regs[i] = 8'h00;
    hold(6);
    rst = 1'b0;
    foreach (ra[i]) begin
      host_u.rd(ra[i], v);
      check(v, 8'h00);
    end
    repeat (2) begin
      foreach (ra[i]) begin
        c = 8'($urandom());
        host_u.wr(ra[i], c, 1'b0);
        if (ra[i] != 8'h20) regs[ra[i]] = c;
      end
      c = regs[8'h13];
      check(8'({clock_pin_is_clock_input, clock_pin_is_second_general_output, clock_pin_pulldown,
        enable_pin_pulldown, spread_spectrum_on}), 8'({c[4], ~c[4], c[3], c[2], c[0]}));
      foreach (ra[i]) begin
        host_u.rd(ra[i], v);
        check(v, regs[ra[i]]);
      end
    end
    c = {3'b010, 5'($urandom_range(23))};
    host_u.wr(OFS_PLL_CLOCK_CONTROL, c, 1'b0);
    host_u.wr(OFS_PLL_CLOCK_CONTROL, 8'hB8 | 8'($urandom_range(7)), 1'b1);
    host_u.rd(OFS_PLL_CLOCK_CONTROL, v);
    check(v, {3'b101, c[4:0]});
    check(8'(external_clock_freq_code), 8'(c[4:0]));
    mode_standby_or_active = 1'b1;
    host_u.wr(OFS_DEVICE_CONFIGURATION, 8'h10, 1'b0);
    host_u.wr(OFS_PLL_CLOCK_CONTROL, c, 1'b0);
    check(8'(pll_enable), 8'h01);
    for (int k = 1; k >= 0; k--) begin
      external_clock_present = k[0];
      wait_on(1'b1, 1'b1, 10);
      hold(2);
      check(8'(use_external_clock), 8'(k[0]));
    end
    host_u.wr(OFS_PLL_CLOCK_CONTROL, 8'h00, 1'b0);
    external_clock_present = 1'b1;
    hold(6);
    check(8'(use_external_clock), 8'h00);
    mode_standby_or_active = 1'b0;
    host_u.wr(OFS_PLL_CLOCK_CONTROL, 8'h40, 1'b0);
    hold(2);
    check(8'({pll_enable, use_external_clock}), 8'h00);
    die_above_low_threshold = 1'b1;
    for (int k = 0; k < 4; k++) begin
      die_above_high_threshold = k[0];
      host_u.wr(OFS_DEVICE_CONFIGURATION, {6'h00, k[1], 1'b0}, 1'b0);
      hold(5);
      check(8'(thermal_warning), k[1] ? 8'(k[0]) : 8'h01);
    end
    repeat (24) begin
      v = 8'($urandom());
      host_u.wr(OFS_POWER_OK_CONTROL_ONE, v, 1'b0);
      host_u.rd(OFS_POWER_OK_CONTROL_ONE, c);
      check(c, v);
      rail_under_ok = 4'($urandom()) | 4'($urandom());
      rail_over_ok = 4'($urandom()) | 4'($urandom());
      hold(5);
      ok = 1'b1;
      for (int i = 0; i < 4; i++) begin
        if (v[i] && !(rail_under_ok[i] && (rail_over_ok[i] || !v[i < 2 ? 4 : 5]))) ok = 1'b0;
      end
      check(8'({power_ok_output_out, power_ok_output_oe}),
        v[6] ? 8'({1'b0, ~(ok ^ v[7])}) : 8'({ok ^ v[7], 1'b1}));
    end
    for (int w = 0; w < 2; w++) begin
      host_u.wr(OFS_DEVICE_CONFIGURATION, w ? 8'h60 : 8'h00, 1'b0);
      host_u.wr(OFS_RAIL_DELAY_BASE, 8'h33, 1'b0);
      t = 3 * (w + 1) * HM;
      enable_pin = 1'b1;
      wait_on(1'b0, 1'b1, 200);
      check(8'(n >= t && n <= t + HM + 6), 8'h01);
      check(8'(rail_enable), 8'h0F);
      enable_pin = 1'b0;
      wait_on(1'b0, 1'b0, 200);
      check(8'(n >= t && n <= t + HM + 6), 8'h01);
      check(8'(rail_enable), 8'h00);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
